// file: rtl/disk_seq_map.svh
// Constants for the disk controller microsequencer: field positions,
// encodings, reset values and timing counts. Included by package and core.
`ifndef DISK_SEQ_MAP_SVH
`define DISK_SEQ_MAP_SVH

// Store and RAM geometry
`define STORE_DEPTH      1024
`define STORE_AW         10
`define RAM_DEPTH        512
`define RAM_AW           9
`define RAM_BUF_LAST     9'h0ff
`define RAM_WORK_FIRST   9'h100

// Instruction word fields
`define F_CLASS_HI       15
`define F_CLASS_LO       14
`define F_REGOP_HI       14
`define F_REGOP_LO       12
`define F_FN_HI          13
`define F_FN_LO          10
`define F_SUB_HI         13
`define F_SUB_LO         12
`define F_MODE_HI        11
`define F_MODE_LO        10
`define F_SEL_HI         9
`define F_SEL_LO         8
`define F_OPND_HI        7
`define F_OPND_LO        0

// Status bit positions (documented bit n sits at index n-1)
`define IS_WORD_READY    0
`define IS_ADDR_TOP      1
`define IS_DELAY         2
`define IS_DRIVE1        3
`define IS_SELECT        4
`define IS_BYTE_READY    5
`define IS_DRIVE2        6
`define IS_HOST_BUSY     7
`define DS_INDEX         0
`define DS_SECTOR        4
`define DS_TRACK0        5
`define DS_CARRY         6

// Reset values
`define RST_PC           10'h000
`define RST_RAM_ADDR     9'h000
`define RST_INSTR        16'h0000
`define RST_BYTE         8'h00

// Timing
`define CLK_HZ           64'd50000000
`define DELAY_MS         64'd40
`define DELAY_W          21
`define DELAY_CYCLES     ((`DELAY_MS * `CLK_HZ) / 64'd1000)

`endif

// file: rtl/disk_seq_pkg.sv
// Types shared by the disk controller microsequencer.
// Assumes disk_seq_map.svh on the include path.
`include "disk_seq_map.svh"

package disk_seq_pkg;

  typedef enum logic [1:0] {PH_FETCH = 2'b01, PH_EXEC = 2'b10} phase_t;

  typedef enum logic [1:0] {CL_REG0 = 2'b00, CL_REG1 = 2'b01, CL_IMM = 2'b10, CL_CTRL = 2'b11} iclass_t;

  typedef enum logic [1:0] {SEL_A = 2'b00, SEL_K = 2'b01, SEL_IS = 2'b10, SEL_DS = 2'b11} regsel_t;

  typedef enum logic [1:0] {RM_HOLD = 2'b00, RM_INC = 2'b01, RM_DEC = 2'b10, RM_PRESET = 2'b11} rammode_t;

  typedef enum logic [3:0] {
    FN_PASS_A = 4'h0, FN_PASS_B = 4'h1, FN_ADD  = 4'h2, FN_ADC  = 4'h3,
    FN_SUB    = 4'h4, FN_SBC    = 4'h5, FN_AND  = 4'h6, FN_OR   = 4'h7,
    FN_XOR    = 4'h8, FN_NOT_A  = 4'h9, FN_INC  = 4'ha, FN_DEC  = 4'hb,
    FN_NAND   = 4'hc, FN_NOR    = 4'hd, FN_XNOR = 4'he, FN_ZERO = 4'hf
  } alufn_t;

  typedef struct packed {
    logic hostStrobe;
    logic hostBusy;
    logic selAb6;
    logic selAb8;
    logic drive1Loaded;
    logic drive2Loaded;
    logic indexPulse;
    logic sectorPulse;
    logic trackZero;
    logic diskBitTick;
    logic [7:0] hostByte;
    logic [7:0] diskReadByte;
  } pins_t;

  typedef struct packed {
    phase_t                phase;
    logic [9:0]            pc;
    logic [15:0]           instr;
    logic [8:0]            ramAddr;
    logic [7:0]            aReg;
    logic [7:0]            kReg;
    logic                  carry;
    logic [3:0]            wordCnt;
    logic                  tickPrev;
    logic [`DELAY_W-1:0]   delayCnt;
    logic [7:0]            hostOut;
    pins_t                 syncA;
    pins_t                 syncB;
  } state_t;

endpackage

// file: rtl/disk_seq.sv
// Microprogrammed datapath of a floppy-disk controller: store, sequencer,
// working RAM, ALU, A/K registers and two status registers.
// Assumes one clock; drive and host pins arrive asynchronously.
`include "disk_seq_map.svh"

module disk_seq #(
  parameter logic [`DELAY_W-1:0] DELAY_CYCLES = `DELAY_W'(`DELAY_CYCLES)
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Microprogram load
  input  wire logic        progWe,
  input  wire logic [9:0]  progAddr,
  input  wire logic [15:0] progData,
  // Host side
  input  wire logic [7:0]  hostByte,
  input  wire logic        hostStrobe,
  input  wire logic        hostBusy,
  input  wire logic        selAb6,
  input  wire logic        selAb8,
  output logic      [7:0]  hostDataOut,
  // Drive side
  input  wire logic        drive1Loaded,
  input  wire logic        drive2Loaded,
  input  wire logic        indexPulse,
  input  wire logic        sectorPulse,
  input  wire logic        trackZero,
  input  wire logic        diskBitTick,
  input  wire logic [7:0]  diskReadByte,
  output logic      [7:0]  diskWriteByte,
  // CRC checker, same clock
  input  wire logic [7:0]  crcByte,
  // Observation
  output logic      [9:0]  microstepCounter,
  output logic      [15:0] instrWord,
  output logic      [7:0]  inputStatusReg,
  output logic      [7:0]  driveStatusReg
);

  disk_seq_pkg::state_t s_q, s_d;
  disk_seq_pkg::pins_t  pinsIn;

  // Two byte-wide memories read side by side
  logic [7:0] storeHi [`STORE_DEPTH];
  logic [7:0] storeLo [`STORE_DEPTH];
  logic [7:0] ram     [`RAM_DEPTH];

  logic [15:0] rawWord;
  logic [7:0]  ramRd;
  logic [7:0]  aBus;
  logic [7:0]  bBus;
  logic [7:0]  cBus;
  logic        carryOut;
  logic        arith;
  logic        useCarry;
  logic [8:0]  sum;
  disk_seq_pkg::alufn_t  fn;
  disk_seq_pkg::iclass_t cls;
  disk_seq_pkg::regsel_t sel;
  logic [2:0]  regOp;
  logic [1:0]  sub;
  logic [1:0]  mode;
  logic [7:0]  opnd;
  logic        exec;
  logic        destReg;
  logic        destRam;
  logic        branch;
  logic [9:0]  target;
  logic        delayStart;

  assign pinsIn = '{hostStrobe: hostStrobe, hostBusy: hostBusy, selAb6: selAb6, selAb8: selAb8,
                    drive1Loaded: drive1Loaded, drive2Loaded: drive2Loaded, indexPulse: indexPulse,
                    sectorPulse: sectorPulse, trackZero: trackZero, diskBitTick: diskBitTick,
                    hostByte: hostByte, diskReadByte: diskReadByte};

  assign rawWord = {storeHi[s_q.pc], storeLo[s_q.pc]};
  assign ramRd   = ram[s_q.ramAddr];

  // Field split of the latched word
  assign cls   = disk_seq_pkg::iclass_t'(s_q.instr[`F_CLASS_HI:`F_CLASS_LO]);
  assign regOp = s_q.instr[`F_REGOP_HI:`F_REGOP_LO];
  assign sub   = s_q.instr[`F_SUB_HI:`F_SUB_LO];
  assign mode  = s_q.instr[`F_MODE_HI:`F_MODE_LO];
  assign sel   = disk_seq_pkg::regsel_t'(s_q.instr[`F_SEL_HI:`F_SEL_LO]);
  assign opnd  = s_q.instr[`F_OPND_HI:`F_OPND_LO];
  assign exec  = (s_q.phase == disk_seq_pkg::PH_EXEC);

  // Status registers; carry, word count, RAM address top and delay come from state, the rest are synchronised levels
  always_comb begin
    inputStatusReg = 8'h00;
    inputStatusReg[`IS_WORD_READY] = s_q.wordCnt[3];
    inputStatusReg[`IS_ADDR_TOP]   = s_q.ramAddr[8];
    inputStatusReg[`IS_DELAY]      = (s_q.delayCnt != '0);
    inputStatusReg[`IS_DRIVE1]     = s_q.syncB.drive1Loaded;
    inputStatusReg[`IS_SELECT]     = s_q.syncB.selAb6 & s_q.syncB.selAb8;
    inputStatusReg[`IS_BYTE_READY] = s_q.syncB.hostStrobe;
    inputStatusReg[`IS_DRIVE2]     = s_q.syncB.drive2Loaded;
    inputStatusReg[`IS_HOST_BUSY]  = s_q.syncB.hostBusy;
    driveStatusReg = 8'h00;
    driveStatusReg[`DS_INDEX]  = s_q.syncB.indexPulse;
    driveStatusReg[`DS_SECTOR] = s_q.syncB.sectorPulse;
    driveStatusReg[`DS_TRACK0] = s_q.syncB.trackZero;
    driveStatusReg[`DS_CARRY]  = s_q.carry;
  end

  // Operand buses and function decode
  always_comb begin
    unique case (sel)
      disk_seq_pkg::SEL_A:  aBus = s_q.aReg;
      disk_seq_pkg::SEL_K:  aBus = s_q.kReg;
      disk_seq_pkg::SEL_IS: aBus = inputStatusReg;
      disk_seq_pkg::SEL_DS: aBus = driveStatusReg;
    endcase
    bBus    = s_q.instr[`F_CLASS_HI] ? opnd : ramRd;
    destRam = 1'b0;
    destReg = 1'b0;
    fn      = disk_seq_pkg::FN_PASS_A;
    if (!s_q.instr[`F_CLASS_HI]) begin
      destReg = (regOp != 3'd0) && (regOp != 3'd1);
      destRam = (regOp == 3'd1);
      unique case (regOp)
        3'd0: fn = disk_seq_pkg::FN_PASS_A;
        3'd1: fn = disk_seq_pkg::FN_PASS_A;
        3'd2: fn = disk_seq_pkg::FN_PASS_B;
        3'd3: fn = disk_seq_pkg::FN_ADD;
        3'd4: fn = disk_seq_pkg::FN_OR;
        3'd5: fn = disk_seq_pkg::FN_XOR;
        3'd6: fn = disk_seq_pkg::FN_ADC;
        3'd7: fn = disk_seq_pkg::FN_AND;
      endcase
    end else if (cls == disk_seq_pkg::CL_IMM) begin
      destReg = 1'b1;
      fn      = disk_seq_pkg::alufn_t'(s_q.instr[`F_FN_HI:`F_FN_LO]);
    end
  end

  // Sixteen-function ALU; subtract carry means no borrow
  always_comb begin
    useCarry = (fn == disk_seq_pkg::FN_ADC) || (fn == disk_seq_pkg::FN_SBC);
    arith    = 1'b1;
    sum      = 9'h000;
    unique case (fn)
      disk_seq_pkg::FN_ADD:  sum = {1'b0, aBus} + {1'b0, bBus};
      disk_seq_pkg::FN_ADC:  sum = {1'b0, aBus} + {1'b0, bBus} + {8'h00, s_q.carry};
      disk_seq_pkg::FN_SUB:  sum = {1'b0, aBus} + {1'b0, ~bBus} + 9'h001;
      disk_seq_pkg::FN_SBC:  sum = {1'b0, aBus} + {1'b0, ~bBus} + {8'h00, s_q.carry};
      disk_seq_pkg::FN_INC:  sum = {1'b0, aBus} + 9'h001;
      disk_seq_pkg::FN_DEC:  sum = {1'b0, aBus} + 9'h0ff;
      disk_seq_pkg::FN_PASS_A: begin sum = {1'b0, aBus};          arith = 1'b0; end
      disk_seq_pkg::FN_PASS_B: begin sum = {1'b0, bBus};          arith = 1'b0; end
      disk_seq_pkg::FN_AND:    begin sum = {1'b0, aBus & bBus};   arith = 1'b0; end
      disk_seq_pkg::FN_OR:     begin sum = {1'b0, aBus | bBus};   arith = 1'b0; end
      disk_seq_pkg::FN_XOR:    begin sum = {1'b0, aBus ^ bBus};   arith = 1'b0; end
      disk_seq_pkg::FN_NOT_A:  begin sum = {1'b0, ~aBus};         arith = 1'b0; end
      disk_seq_pkg::FN_NAND:   begin sum = {1'b0, ~(aBus & bBus)}; arith = 1'b0; end
      disk_seq_pkg::FN_NOR:    begin sum = {1'b0, ~(aBus | bBus)}; arith = 1'b0; end
      disk_seq_pkg::FN_XNOR:   begin sum = {1'b0, ~(aBus ^ bBus)}; arith = 1'b0; end
      disk_seq_pkg::FN_ZERO:   begin sum = 9'h000;                arith = 1'b0; end
    endcase
    cBus     = sum[7:0];
    carryOut = sum[8];
  end

  // Branch decision; conditional targets stay in the current 256-step page
  always_comb begin
    branch = 1'b0;
    target = {s_q.pc[9:8], opnd};
    if (cls == disk_seq_pkg::CL_CTRL) begin
      unique case (sub)
        2'd0: begin branch = 1'b1; target = {s_q.instr[`F_SEL_HI:`F_SEL_LO], opnd}; end
        2'd1: branch = (aBus == 8'h00);
        2'd2: branch = (aBus != 8'h00);
        2'd3: branch = 1'b0;
      endcase
    end
  end

  assign delayStart = exec && destReg && (sel == disk_seq_pkg::SEL_IS) && cBus[`IS_DELAY];

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.syncA   = pinsIn;
    s_d.syncB   = s_q.syncA;
    s_d.hostOut = ramRd;
    // Word counter clocked by the disk bit tick
    s_d.tickPrev = s_q.syncB.diskBitTick;
    if (s_q.syncB.diskBitTick && !s_q.tickPrev) begin
      s_d.wordCnt = s_q.wordCnt + 4'h1;
    end
    // Delay runs from its start for the full count
    if (delayStart) begin
      s_d.delayCnt = DELAY_CYCLES;
    end else if (s_q.delayCnt != '0) begin
      s_d.delayCnt = s_q.delayCnt - `DELAY_W'(1);
    end
    if (!exec) begin
      s_d.instr = rawWord;
      s_d.phase = disk_seq_pkg::PH_EXEC;
    end else begin
      s_d.phase = disk_seq_pkg::PH_FETCH;
      s_d.pc    = branch ? target : s_q.pc + 10'h001;
      if (!s_q.instr[`F_CLASS_HI] && regOp != 3'd0) begin
        unique case (mode)
          disk_seq_pkg::RM_INC:    s_d.ramAddr = s_q.ramAddr + 9'h001;
          disk_seq_pkg::RM_DEC:    s_d.ramAddr = s_q.ramAddr - 9'h001;
          disk_seq_pkg::RM_HOLD,
          disk_seq_pkg::RM_PRESET: s_d.ramAddr = s_q.ramAddr;
        endcase
      end
      if (arith && (destReg || destRam)) begin
        s_d.carry = carryOut;
      end
      if (destReg) begin
        unique case (sel)
          disk_seq_pkg::SEL_A:  s_d.aReg  = cBus;
          disk_seq_pkg::SEL_K:  s_d.kReg  = cBus;
          disk_seq_pkg::SEL_DS: s_d.carry = cBus[`DS_CARRY];
          disk_seq_pkg::SEL_IS: s_d.carry = s_d.carry;
        endcase
      end
      if (cls == disk_seq_pkg::CL_CTRL && sub == 2'd3) begin
        unique case (mode)
          2'd0: s_d.ramAddr = {s_q.instr[`F_SEL_LO], opnd};
          2'd1: s_d.kReg    = s_q.syncB.hostByte;
          2'd2: s_d.aReg    = ramRd;
          2'd3: s_d.aReg    = s_q.instr[`F_SEL_LO] ? crcByte : s_q.syncB.diskReadByte;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.phase <= disk_seq_pkg::PH_FETCH;
      s_q.pc    <= `RST_PC;
      s_q.instr <= `RST_INSTR;
      s_q.ramAddr <= `RST_RAM_ADDR;
      s_q.carry <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Memories carry no reset; the store is loaded before the sequencer runs
  always_ff @(posedge ref_clk) begin
    if (progWe) begin
      storeHi[progAddr] <= progData[15:8];
      storeLo[progAddr] <= progData[7:0];
    end
    if (exec && destRam) begin
      ram[s_q.ramAddr] <= cBus;
    end
  end

  assign hostDataOut      = s_q.hostOut;
  assign diskWriteByte    = s_q.aReg;
  assign microstepCounter = s_q.pc;
  assign instrWord        = s_q.instr;

  // Checks
  a_pc_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && !branch |=> s_q.pc == $past(s_q.pc) + 10'h001)
    else $error("counter did not advance by one");

  a_pc_branch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && branch |=> s_q.pc == $past(target))
    else $error("branch target not loaded");

  a_word_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !exec |=> exec && s_q.instr == $past(rawWord))
    else $error("store word not latched");

  a_ram_inc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && !s_q.instr[15] && regOp != 3'd0 && mode == 2'd1 |=> s_q.ramAddr == $past(s_q.ramAddr) + 9'h001)
    else $error("RAM address did not increment");

  a_ram_dec: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && !s_q.instr[15] && regOp != 3'd0 && mode == 2'd2 |=> s_q.ramAddr == $past(s_q.ramAddr) - 9'h001)
    else $error("RAM address did not decrement");

  a_ram_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && destRam ##1 !progWe |-> ram[$past(s_q.ramAddr)] == $past(cBus))
    else $error("RAM not written with ALU result");

  a_k_host_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && cls == disk_seq_pkg::CL_CTRL && sub == 2'd3 && mode == 2'd1
    |=> s_q.kReg == $past(s_q.syncB.hostByte))
    else $error("K did not take host byte");

  a_k_alu_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && destReg && sel == disk_seq_pkg::SEL_K |=> s_q.kReg == $past(cBus))
    else $error("K did not take ALU result");

  a_delay_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
    delayStart |=> inputStatusReg[2] && s_q.delayCnt == DELAY_CYCLES)
    else $error("delay not started");

  a_delay_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.delayCnt == `DELAY_W'(1) && !delayStart |=> !inputStatusReg[`IS_DELAY])
    else $error("delay did not end");

  a_addr_top: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && cls == disk_seq_pkg::CL_CTRL && sub == 2'd3 && mode == 2'd0
    |=> inputStatusReg[`IS_ADDR_TOP] == $past(s_q.instr[`F_SEL_LO]))
    else $error("address top bit not shown");

  a_carry_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && arith && destReg && sel != disk_seq_pkg::SEL_DS |=> driveStatusReg[6] == $past(carryOut))
    else $error("carry-out not captured");

  a_byte_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hostStrobe) |-> ##2 inputStatusReg[`IS_BYTE_READY])
    else $error("byte ready not shown");

  a_reset_clear: assert property (@(posedge ref_clk)
    !rst_n |=> s_q.pc == 10'h000 && s_q.ramAddr == 9'h000 && !s_q.carry && !exec)
    else $error("reset did not clear state");

endmodule

// file: sim/disk_seq_far_end.sv
// Behavioural host computer and floppy drive facing the controller pins.
// Assumes the bench sets wanted levels at the falling edge; lines follow at once, only the bit clock moves after the rising edge.
module disk_seq_far_end (
  // Clock
  input  wire logic                ref_clk,
  // Bench control
  input  wire disk_seq_pkg::pins_t want,
  input  wire logic                tickEn,
  // Lines to the controller
  output disk_seq_pkg::pins_t      pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic tickQ = 1'b0;

  // Bit clock stands still outside a frame
  always @(posedge ref_clk) begin
    tickQ <= tickEn ? !tickQ : 1'b0;
  end

  // Lines pass the wanted levels straight through; only the bit clock is made here
  always_comb begin
    pins             = want;
    pins.diskBitTick = tickQ;
  end
endmodule

// file: sim/disk_seq_tb.sv
// Self-checking bench for the disk controller microsequencer.
// Assumes disk_seq_pkg compiled first; programs are loaded while reset is held.
module disk_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                ref_clk  = 1'b0;
  logic                rst_n    = 1'b0;
  logic                progWe   = 1'b0;
  logic [9:0]          progAddr = 10'h000;
  logic [15:0]         progData = 16'h0000;
  logic [7:0]          crcByte  = 8'h3e;
  logic                tickEn   = 1'b0;
  disk_seq_pkg::pins_t want     = '0;
  disk_seq_pkg::pins_t pins;
  logic [7:0]          hostDataOut, diskWriteByte, inputStatusReg, driveStatusReg;
  logic [9:0]          microstepCounter;
  logic [15:0]         instrWord;
  int                  fails    = 0;
  int                  compares = 0;
  int                  cycles   = 0;

  localparam logic [9:0]  PB_A [20] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006,
    10'h007, 10'h008, 10'h009, 10'h00a, 10'h020, 10'h310, 10'h311, 10'h312, 10'h313, 10'h314, 10'h315,
    10'h316, 10'h3ff};
  localparam logic [15:0] PB_W [20] = '{16'hf100, 16'h845a, 16'h1400, 16'h8477, 16'h1800, 16'h2100,
    16'hf800, 16'h840f, 16'h3000, 16'hd020, 16'he020, 16'hc310, 16'hf400, 16'h1100, 16'hf800, 16'ha1ff,
    16'h1100, 16'hf800, 16'hc3ff, 16'h8604};
  localparam logic [8:0]  PIN_V [10] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h060, 9'h010, 9'h008, 9'h004,
    9'h002, 9'h001};
  localparam logic [15:0] PIN_E [10] = '{16'h2000, 16'h8000, 16'h0000, 16'h0000, 16'h1000, 16'h0800,
    16'h4000, 16'h0001, 16'h0010, 16'h0020};

  // Short delay keeps the run brief
  disk_seq #(.DELAY_CYCLES(21'h14)) u_disk_seq (
    .ref_clk(ref_clk), .rst_n(rst_n), .progWe(progWe), .progAddr(progAddr), .progData(progData),
    .hostByte(pins.hostByte), .hostStrobe(pins.hostStrobe), .hostBusy(pins.hostBusy),
    .selAb6(pins.selAb6), .selAb8(pins.selAb8), .hostDataOut(hostDataOut),
    .drive1Loaded(pins.drive1Loaded), .drive2Loaded(pins.drive2Loaded), .indexPulse(pins.indexPulse),
    .sectorPulse(pins.sectorPulse), .trackZero(pins.trackZero), .diskBitTick(pins.diskBitTick),
    .diskReadByte(pins.diskReadByte), .diskWriteByte(diskWriteByte), .crcByte(crcByte),
    .microstepCounter(microstepCounter), .instrWord(instrWord), .inputStatusReg(inputStatusReg),
    .driveStatusReg(driveStatusReg)
  );

  disk_seq_far_end u_disk_seq_far_end (.ref_clk(ref_clk), .want(want), .tickEn(tickEn), .pins(pins));

  always #10 ref_clk = ~ref_clk;

  // Hang guard: the whole sequence needs well under this
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic load(input logic [9:0] a, input logic [15:0] w);
    @(negedge ref_clk);
    progWe   = 1'b1;
    progAddr = a;
    progData = w;
    @(negedge ref_clk);
    progWe   = 1'b0;
  endtask

  task automatic holdReset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask

  // One step is a fetch edge and an execute edge
  task automatic go(input int n);
    repeat (2 * n) @(negedge ref_clk);
  endtask

  function automatic logic [8:0] aluExp(input logic [3:0] f, input logic [7:0] a, input logic [7:0] b);
    case (f)
      4'h0: return {1'b0, a};
      4'h1: return {1'b0, b};
      4'h2, 4'h3: return {1'b0, a} + {1'b0, b};
      4'h4: return {1'b0, a} + {1'b0, ~b} + 9'h001;
      4'h5: return {1'b0, a} + {1'b0, ~b};
      4'h6: return {1'b0, a & b};
      4'h7: return {1'b0, a | b};
      4'h8: return {1'b0, a ^ b};
      4'h9: return {1'b0, ~a};
      4'ha: return {1'b0, a} + 9'h001;
      4'hb: return {1'b0, a} + 9'h0ff;
      4'hc: return {1'b0, ~(a & b)};
      4'hd: return {1'b0, ~(a | b)};
      4'he: return {1'b0, ~(a ^ b)};
      default: return 9'h000;
    endcase
  endfunction

  initial begin
    logic [8:0] e;
    logic       cin;
    int         n;
    // Datapath walk: RAM, branches, host byte, delay
    holdReset();
    for (int i = 0; i < 20; i++) load(PB_A[i], PB_W[i]);
    want.hostByte   = 8'hc6;
    want.hostStrobe = 1'b1;
    @(negedge ref_clk);
    rst_n = 1'b1;
    chk({6'h00, microstepCounter}, 16'h0000);
    go(1);
    chk(instrWord, 16'hf100);
    chk({15'h0000, inputStatusReg[1]}, 16'h0001);
    go(6);
    chk({8'h00, diskWriteByte}, 16'h005a);
    chk({8'h00, hostDataOut}, 16'h005a);
    go(2);
    chk({8'h00, diskWriteByte}, 16'h0069);
    go(2);
    chk({6'h00, microstepCounter}, 16'h0020);
    go(1);
    chk({6'h00, microstepCounter}, 16'h0310);
    chk({15'h0000, inputStatusReg[5]}, 16'h0001);
    go(3);
    chk({8'h00, diskWriteByte}, 16'h00c6);
    go(3);
    chk({8'h00, diskWriteByte}, 16'h0039);
    go(2);
    chk({6'h00, microstepCounter}, 16'h0000);
    n = 0;
    while (inputStatusReg[2] === 1'b1 && n < 100) begin
      n++;
      @(negedge ref_clk);
    end
    chk(16'(n), 16'h0014);
    // Parked program: disk and CRC bytes into A, then status lines
    holdReset();
    load(10'h000, 16'h0000);
    load(10'h001, 16'hfc00);
    load(10'h002, 16'hfd00);
    load(10'h003, 16'hc003);
    want = '0;
    want.diskReadByte = 8'hb4;
    @(negedge ref_clk);
    rst_n = 1'b1;
    chk({15'h0000, inputStatusReg[1]}, 16'h0000);
    go(2);
    chk({8'h00, diskWriteByte}, 16'h00b4);
    go(1);
    chk({8'h00, diskWriteByte}, 16'h003e);
    for (int i = 0; i < 10; i++) begin
      {want.hostStrobe, want.hostBusy, want.selAb6, want.selAb8, want.drive1Loaded, want.drive2Loaded,
       want.indexPulse, want.sectorPulse, want.trackZero} = PIN_V[i];
      repeat (4) @(negedge ref_clk);
      chk({inputStatusReg, driveStatusReg}, PIN_E[i]);
    end
    // Eight bit-clock rises set the top stage, eight more clear it
    for (int k = 0; k < 2; k++) begin
      tickEn = 1'b1;
      repeat (16) @(negedge ref_clk);
      tickEn = 1'b0;
      repeat (5) @(negedge ref_clk);
      chk({15'h0000, inputStatusReg[0]}, 16'(1 - k));
    end
    // Every ALU function, then carry fed back through an add-with-carry
    for (int f = 0; f < 16; f++) begin
      e   = aluExp(4'(f), 8'hc3, 8'ha5);
      cin = ((f >= 2 && f <= 5) || f == 10 || f == 11) ? e[8] : 1'b0;
      holdReset();
      load(10'h000, 16'h84c3);
      load(10'h001, {2'b10, 4'(f), 2'b00, 8'ha5});
      load(10'h002, 16'h8c00);
      load(10'h003, 16'hc003);
      @(negedge ref_clk);
      rst_n = 1'b1;
      chk({15'h0000, driveStatusReg[6]}, 16'h0000);
      go(2);
      chk({8'h00, diskWriteByte}, {8'h00, e[7:0]});
      chk({15'h0000, driveStatusReg[6]}, {15'h0000, cin});
      go(1);
      chk({8'h00, diskWriteByte}, {8'h00, e[7:0] + {7'h00, cin}});
    end
    summarize();
  end
endmodule
